// >>> src/uax_baud_gen.sv
`timescale 1ns/1ps
`default_nettype none
module uax_baud_gen
  import uax_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Divisor
  input wire logic [15:0] divisor,
  input wire logic [UAX_FRAC_W-1:0] frac,
  // Oversampling enable
  output logic tick16
);
  typedef struct packed {
    logic [15:0] cnt;
    logic [UAX_FRAC_W-1:0] acc;
    logic tick;
  } uax_baud_st_t;

  uax_baud_st_t st_r;
  uax_baud_st_t st_nxt;
  logic [UAX_FRAC_W:0] sum;

  // Period is divisor cycles, one extra whenever the sixteenths overflow
  always_comb begin
    st_nxt = st_r;
    sum = {1'b0, st_r.acc} + {1'b0, frac};
    st_nxt.tick = 1'b0;
    if (divisor == 16'h0000) begin
      st_nxt.cnt = 16'h0000;
    end else if (st_r.cnt == 16'h0000) begin
      st_nxt.tick = 1'b1;
      st_nxt.acc = sum[UAX_FRAC_W-1:0];
      st_nxt.cnt = divisor - 16'h0001 + {15'h0000, sum[UAX_FRAC_W]};
    end else begin
      st_nxt.cnt = st_r.cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick16 = st_r.tick;

  // Gap counter starts saturated, so the first tick after reset or after
  // the divisor leaves zero is not judged against a spacing it never had
  logic [16:0] gap_r;
  always_ff @(posedge clk) begin
    if (rst || divisor == 16'h0000) begin
      gap_r <= 17'h1ffff;
    end else if (st_r.tick) begin
      gap_r <= 17'h00001;
    end else if (gap_r != 17'h1ffff) begin
      gap_r <= gap_r + 17'h00001;
    end
  end

  tick_gap_a: assert property (@(posedge clk) disable iff (rst)
    st_r.tick && $past(st_r.tick, 1) == 1'b0 && $stable(divisor) && frac == '0
    && gap_r < 17'h1ffff |-> gap_r[15:0] == divisor || gap_r[15:0] == divisor + 16'h0001)
    else $error("baud tick spacing differs from divisor");
endmodule // uax_baud_gen
`default_nettype wire

// >>> src/uax_pkg.sv
package uax_pkg;
  // Printed offsets are kept whole; the local index is the offset from the block base
  localparam logic [31:0] UAX_BASE = 32'h50001000;
  localparam logic [31:0] UAX_OFS_STET = 32'h500010a0;
  localparam logic [31:0] UAX_OFS_HALT = 32'h500010a4;
  localparam logic [31:0] UAX_OFS_ACK = 32'h500010a8;
  localparam logic [31:0] UAX_OFS_FRAC = 32'h500010c0;
  localparam logic [31:0] UAX_OFS_VERL = 32'h500010f8;
  localparam logic [31:0] UAX_OFS_VERH = 32'h500010fa;
  localparam logic [31:0] UAX_OFS_TYPL = 32'h500010fc;
  localparam logic [31:0] UAX_OFS_TYPH = 32'h500010fe;
  localparam logic [7:0] UAX_IX_STET = 8'(UAX_OFS_STET - UAX_BASE);
  localparam logic [7:0] UAX_IX_HALT = 8'(UAX_OFS_HALT - UAX_BASE);
  localparam logic [7:0] UAX_IX_ACK = 8'(UAX_OFS_ACK - UAX_BASE);
  localparam logic [7:0] UAX_IX_FRAC = 8'(UAX_OFS_FRAC - UAX_BASE);
  localparam logic [7:0] UAX_IX_VERL = 8'(UAX_OFS_VERL - UAX_BASE);
  localparam logic [7:0] UAX_IX_VERH = 8'(UAX_OFS_VERH - UAX_BASE);
  localparam logic [7:0] UAX_IX_TYPL = 8'(UAX_OFS_TYPL - UAX_BASE);
  localparam logic [7:0] UAX_IX_TYPH = 8'(UAX_OFS_TYPH - UAX_BASE);
  localparam int UAX_AW = 10;
  // Field positions
  localparam int UAX_FCW_FIFO_EN = 0;
  localparam int UAX_FCW_TET_LO = 4;
  localparam int UAX_FCW_TET_HI = 5;
  localparam int UAX_HALT_BIT = 0;
  localparam int UAX_ACK_BIT = 0;
  localparam logic [7:0] UAX_FCW_RST = 8'h00;
  // Transmit-empty thresholds, in characters left
  localparam logic [4:0] UAX_LVL_EMPTY = 5'h00;
  localparam logic [4:0] UAX_LVL_TWO = 5'h02;
  localparam logic [4:0] UAX_LVL_QTR = 5'h04;
  localparam logic [4:0] UAX_LVL_HALF = 5'h08;
  localparam logic [1:0] UAX_TET_EMPTY = 2'h0;
  localparam logic [1:0] UAX_TET_TWO = 2'h1;
  localparam logic [1:0] UAX_TET_QTR = 2'h2;
  // Divisor arithmetic: fraction in sixteenths, 16x oversampling
  localparam int UAX_FRAC_W = 4;
  localparam logic [1:0] UAX_RESP_OKAY = 2'h0;
  localparam logic [1:0] UAX_RESP_SLVERR = 2'h2;
endpackage

// >>> src/uax_regs.sv
`timescale 1ns/1ps
`default_nettype none
module uax_regs
  import uax_pkg::*;
#(
  parameter bit FIFOS_PRESENT = 1'b1,
  // Identification values are arbitrary
  parameter logic [15:0] VERSION_LO = 16'h0001,
  parameter logic [15:0] VERSION_HI = 16'h0002,
  parameter logic [15:0] TYPE_LO = 16'h0003,
  parameter logic [15:0] TYPE_HI = 16'h0004
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // AXI4-Lite write
  input wire logic [UAX_AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read
  input wire logic [UAX_AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // FIFO control word from the main register file
  input wire logic FIFO_CONTROL_WR,
  input wire logic [7:0] FIFO_CONTROL_WDATA,
  output logic [7:0] FIFO_CONTROL_WORD,
  // Transmitter
  input wire logic PROGRAMMABLE_TX_EMPTY_IRQ_MODE,
  input wire logic [4:0] TX_FIFO_LEVEL,
  output logic TX_HOLDING_EMPTY_FLAG,
  output logic TX_HOLD,
  // Bit-rate generator
  input wire logic [15:0] DIVISOR,
  output logic BAUD_TICK16,
  // DMA handshake
  input wire logic DMA_TX_REQ_IN,
  input wire logic DMA_TX_SINGLE_IN,
  input wire logic DMA_RX_REQ_IN,
  input wire logic DMA_RX_SINGLE_IN,
  output logic DMA_TX_REQ,
  output logic DMA_TX_SINGLE,
  output logic DMA_RX_REQ,
  output logic DMA_RX_SINGLE
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic aw_got;
    logic [UAX_AW-1:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] fcw;
    logic halt;
    logic [UAX_FRAC_W-1:0] frac;
    logic ack;
    logic [3:0] dma_blk;
  } uax_regs_st_t;

  uax_regs_st_t st_r;
  uax_regs_st_t st_nxt;
  logic do_wr;
  logic [7:0] wr_ix;
  logic [7:0] rd_ix;
  logic [3:0] dma_in;
  logic [3:0] dma_out;
  logic fifo_en;

  assign do_wr = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign wr_ix = st_r.awaddr[UAX_AW-1:2];
  assign rd_ix = S_AXI_ARADDR[UAX_AW-1:2];
  assign dma_in = {DMA_RX_SINGLE_IN, DMA_RX_REQ_IN, DMA_TX_SINGLE_IN, DMA_TX_REQ_IN};
  assign fifo_en = st_r.fcw[UAX_FCW_FIFO_EN];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    // Address and data may arrive in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = S_AXI_WDATA;
      st_nxt.wstrb = S_AXI_WSTRB;
    end
    // Core write of the whole word first, so a shadow write in the
    // same cycle still lands on the trigger bits
    if (FIFO_CONTROL_WR) begin
      st_nxt.fcw = FIFO_CONTROL_WDATA;
    end
    if (do_wr) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = UAX_RESP_OKAY;
      case (wr_ix)
        UAX_IX_STET: begin
          if (st_r.wstrb[0]) begin
            st_nxt.fcw[UAX_FCW_TET_HI:UAX_FCW_TET_LO] = st_r.wdata[1:0];
          end
        end
        UAX_IX_HALT: begin
          if (st_r.wstrb[0]) begin
            st_nxt.halt = st_r.wdata[UAX_HALT_BIT];
          end
        end
        UAX_IX_ACK: begin
          if (st_r.wstrb[0]) begin
            st_nxt.ack = st_r.wdata[UAX_ACK_BIT];
          end
        end
        UAX_IX_FRAC: begin
          if (st_r.wstrb[0]) begin
            st_nxt.frac = st_r.wdata[UAX_FRAC_W-1:0];
          end
        end
        // Identification words accept and drop the data
        UAX_IX_VERL, UAX_IX_VERH, UAX_IX_TYPL, UAX_IX_TYPH: begin
          st_nxt.bresp = UAX_RESP_OKAY;
        end
        default: begin
          st_nxt.bresp = UAX_RESP_SLVERR;
        end
      endcase
    end
    if (st_r.bvalid && S_AXI_BREADY) begin
      st_nxt.bvalid = 1'b0;
    end
    // Read: data captured at the address handshake
    if (st_r.rvalid && S_AXI_RREADY) begin
      st_nxt.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = UAX_RESP_OKAY;
      st_nxt.rdata = 32'h00000000;
      case (rd_ix)
        UAX_IX_STET: st_nxt.rdata[1:0] = st_r.fcw[UAX_FCW_TET_HI:UAX_FCW_TET_LO];
        UAX_IX_HALT: st_nxt.rdata[UAX_HALT_BIT] = st_r.halt;
        UAX_IX_ACK: st_nxt.rdata = 32'h00000000;
        UAX_IX_FRAC: st_nxt.rdata[UAX_FRAC_W-1:0] = st_r.frac;
        UAX_IX_VERL: st_nxt.rdata[15:0] = VERSION_LO;
        UAX_IX_VERH: st_nxt.rdata[15:0] = VERSION_HI;
        UAX_IX_TYPL: st_nxt.rdata[15:0] = TYPE_LO;
        UAX_IX_TYPH: st_nxt.rdata[15:0] = TYPE_HI;
        default: st_nxt.rresp = UAX_RESP_SLVERR;
      endcase
    end
    // A line stays blocked after an acknowledge until its source drops,
    // so a stale request from the core cannot re-raise it
    for (int i = 0; i < 4; i++) begin
      if (st_r.ack) begin
        st_nxt.dma_blk[i] = 1'b1;
      end else if (!dma_in[i]) begin
        st_nxt.dma_blk[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign S_AXI_AWREADY = !st_r.aw_got && !st_r.bvalid;
  assign S_AXI_WREADY = !st_r.w_got && !st_r.bvalid;
  assign S_AXI_BVALID = st_r.bvalid;
  assign S_AXI_BRESP = st_r.bresp;
  assign S_AXI_ARREADY = !st_r.rvalid;
  assign S_AXI_RVALID = st_r.rvalid;
  assign S_AXI_RDATA = st_r.rdata;
  assign S_AXI_RRESP = st_r.rresp;
  assign FIFO_CONTROL_WORD = st_r.fcw;

  // Halt only bites with FIFOs present and enabled
  assign TX_HOLD = st_r.halt && FIFOS_PRESENT && fifo_en;

  // Acknowledge pulse also masks combinationally so the drop is immediate
  assign dma_out = dma_in & ~st_r.dma_blk & {4{!st_r.ack}};
  assign DMA_TX_REQ = dma_out[0];
  assign DMA_TX_SINGLE = dma_out[1];
  assign DMA_RX_REQ = dma_out[2];
  assign DMA_RX_SINGLE = dma_out[3];

  // ****************************************
  // Submodules
  // ****************************************
  uax_tx_holding_empty_flag_gen u_tx_holding_empty_flag (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .prog_mode(PROGRAMMABLE_TX_EMPTY_IRQ_MODE),
    .fifo_en(fifo_en),
    .trigger(st_r.fcw[UAX_FCW_TET_HI:UAX_FCW_TET_LO]),
    .level(TX_FIFO_LEVEL),
    .tx_holding_empty_flag(TX_HOLDING_EMPTY_FLAG)
  );

  uax_baud_gen u_baud (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .divisor(DIVISOR),
    .frac(st_r.frac),
    .tick16(BAUD_TICK16)
  );

  // ****************************************
  // Checks
  // ****************************************
  shadow_write_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    do_wr && wr_ix == UAX_IX_STET && st_r.wstrb[0] && !FIFO_CONTROL_WR
    |=> st_r.fcw[UAX_FCW_TET_HI:UAX_FCW_TET_LO] == $past(st_r.wdata[1:0])
    && st_r.fcw[3:0] == $past(st_r.fcw[3:0]) && st_r.fcw[7:6] == $past(st_r.fcw[7:6]))
    else $error("shadow write disturbed other bits or missed trigger");

  halt_set_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    do_wr && wr_ix == UAX_IX_HALT && st_r.wstrb[0] && st_r.wdata[0] && fifo_en
    && !FIFO_CONTROL_WR |=> TX_HOLD)
    else $error("halt write did not stop transmitter");

  halt_ignored_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !fifo_en |-> !TX_HOLD)
    else $error("halt acted with FIFOs disabled");

  ack_drop_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    do_wr && wr_ix == UAX_IX_ACK && st_r.wstrb[0] && st_r.wdata[0]
    |=> dma_out == 4'h0 ##1 dma_out == 4'h0)
    else $error("DMA lines not dropped by acknowledge");

  ack_clear_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    st_r.ack |=> !st_r.ack)
    else $error("acknowledge did not clear itself");

  frac_write_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    do_wr && wr_ix == UAX_IX_FRAC && st_r.wstrb[0]
    |=> st_r.frac == $past(st_r.wdata[3:0]) && $stable(st_r.fcw))
    else $error("fraction write lost");

  id_read_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    S_AXI_ARVALID && S_AXI_ARREADY && rd_ix == UAX_IX_TYPH
    |=> S_AXI_RVALID && S_AXI_RDATA == {16'h0000, TYPE_HI})
    else $error("type word read wrong");

  ack_read_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    S_AXI_ARVALID && S_AXI_ARREADY && rd_ix == UAX_IX_ACK
    |=> S_AXI_RDATA == 32'h00000000 && S_AXI_RRESP == UAX_RESP_OKAY)
    else $error("acknowledge register not reading zero");

  // ****************************************
  // Bus and field checks
  // ****************************************
  // A response must not move while the master has not taken it
  bresp_hold_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped or changed before taken");

  rdata_hold_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP))
    else $error("read data dropped or changed before taken");

  halt_clear_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    do_wr && wr_ix == UAX_IX_HALT && st_r.wstrb[0] && !st_r.wdata[0] |=> !TX_HOLD)
    else $error("halt clear did not resume transmitter");

  ack_lines_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    st_r.ack |-> dma_out == 4'h0)
    else $error("DMA line high during acknowledge");

  id_write_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    do_wr && (wr_ix == UAX_IX_VERL || wr_ix == UAX_IX_TYPH) && !FIFO_CONTROL_WR
    |=> $stable(st_r.fcw) && $stable(st_r.halt) && $stable(st_r.frac))
    else $error("identification write changed a register");

  version_read_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    S_AXI_ARVALID && S_AXI_ARREADY && rd_ix == UAX_IX_VERL
    |=> S_AXI_RVALID && S_AXI_RDATA == {16'h0000, VERSION_LO})
    else $error("version word read wrong");

  halt_reserved_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    S_AXI_ARVALID && S_AXI_ARREADY && rd_ix == UAX_IX_HALT
    |=> S_AXI_RDATA[31:1] == 31'h00000000)
    else $error("reserved halt bits not reading zero");

  // Unmapped writes must be refused so software sees a wrong address
  unmapped_wr_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    do_wr && wr_ix != UAX_IX_STET && wr_ix != UAX_IX_HALT && wr_ix != UAX_IX_ACK
    && wr_ix != UAX_IX_FRAC && wr_ix != UAX_IX_VERL && wr_ix != UAX_IX_VERH
    && wr_ix != UAX_IX_TYPL && wr_ix != UAX_IX_TYPH
    |=> S_AXI_BVALID && S_AXI_BRESP == UAX_RESP_SLVERR)
    else $error("unmapped write not refused");

  frac_hold_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !(do_wr && wr_ix == UAX_IX_FRAC) |=> $stable(st_r.frac))
    else $error("fraction changed without a write");

  halt_hold_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !(do_wr && wr_ix == UAX_IX_HALT) |=> $stable(st_r.halt))
    else $error("halt changed without a write");

  // Write side is idle again once the response has been taken
  bus_idle_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY)
    else $error("write side not free after response");
endmodule // uax_regs
`default_nettype wire

// >>> src/uax_tx_holding_empty_flag_gen.sv
`timescale 1ns/1ps
`default_nettype none
module uax_tx_holding_empty_flag_gen
  import uax_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Transmit state
  input wire logic prog_mode,
  input wire logic fifo_en,
  input wire logic [1:0] trigger,
  input wire logic [4:0] level,
  // Interrupt source
  output logic tx_holding_empty_flag
);
  typedef struct packed {
    logic tx_holding_empty_flag;
  } uax_tx_holding_empty_flag_st_t;

  uax_tx_holding_empty_flag_st_t st_r;
  uax_tx_holding_empty_flag_st_t st_nxt;
  logic [4:0] limit;

  always_comb begin
    st_nxt = st_r;
    case (trigger)
      UAX_TET_EMPTY: limit = UAX_LVL_EMPTY;
      UAX_TET_TWO: limit = UAX_LVL_TWO;
      UAX_TET_QTR: limit = UAX_LVL_QTR;
      default: limit = UAX_LVL_HALF;
    endcase
    // Threshold only applies in programmable mode with FIFOs on; otherwise plain empty
    if (prog_mode && fifo_en) begin
      st_nxt.tx_holding_empty_flag = (level <= limit);
    end else begin
      st_nxt.tx_holding_empty_flag = (level == UAX_LVL_EMPTY);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tx_holding_empty_flag = st_r.tx_holding_empty_flag;

  tx_holding_empty_flag_level_a: assert property (@(posedge clk) disable iff (rst)
    prog_mode && fifo_en && trigger == UAX_TET_TWO && level == UAX_LVL_TWO
    ##1 $stable(level) |-> tx_holding_empty_flag)
    else $error("threshold interrupt missing at two characters");
endmodule // uax_tx_holding_empty_flag_gen
`default_nettype wire

// >>> verification/uart_aux_control_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module uart_aux_control_regs_bench;
  import uax_pkg::*;
  localparam logic [7:0] IXS [8] = '{UAX_IX_STET, UAX_IX_HALT, UAX_IX_ACK, UAX_IX_FRAC,
    UAX_IX_VERL, UAX_IX_VERH, UAX_IX_TYPL, UAX_IX_TYPH};
  localparam logic [31:0] EXP [8] = '{0, 0, 0, 0, 1, 2, 3, 4};
  localparam logic [4:0] LVL [4] = '{UAX_LVL_EMPTY, UAX_LVL_TWO, UAX_LVL_QTR, UAX_LVL_HALF};
  logic clk = 1'b0;
  logic rst, awvalid, wvalid, bready, arvalid, rready, fcw_wr, mode;
  logic awready, wready, bvalid, arready, rvalid, tx_holding_empty_flag, hold, tick;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, raise, src, dreq;
  logic [1:0] bresp, rresp, r;
  logic [7:0] fcw_d, fcw_q;
  logic [4:0] lvl;
  logic [15:0] div;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  int n;
  always #12.5 clk = ~clk;
  uax_regs u_uax_regs (.CORE_CLK(clk), .SYS_RST(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .FIFO_CONTROL_WR(fcw_wr), .FIFO_CONTROL_WDATA(fcw_d), .FIFO_CONTROL_WORD(fcw_q),
    .PROGRAMMABLE_TX_EMPTY_IRQ_MODE(mode), .TX_FIFO_LEVEL(lvl),
    .TX_HOLDING_EMPTY_FLAG(tx_holding_empty_flag), .TX_HOLD(hold), .DIVISOR(div), .BAUD_TICK16(tick),
    .DMA_TX_REQ_IN(src[0]), .DMA_TX_SINGLE_IN(src[1]), .DMA_RX_REQ_IN(src[2]),
    .DMA_RX_SINGLE_IN(src[3]), .DMA_TX_REQ(dreq[0]), .DMA_TX_SINGLE(dreq[1]),
    .DMA_RX_REQ(dreq[2]), .DMA_RX_SINGLE(dreq[3]));
  uax_dma_peer u_uax_dma_peer (.clk(clk), .rst(rst), .raise(raise), .req(dreq), .src(src));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_of_test;
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [9:0] ba(input logic [7:0] ix);
    ba = {ix, 2'b00};
  endfunction

  // Handshakes are judged at the falling edge, acted on after the next rising edge
  task automatic axw(input logic [9:0] a, input logic [31:0] dat, output logic [1:0] resp);
    bit aw_t, w_t, b_t;
    @(posedge clk);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_t = 0;
    while (!b_t) begin
      @(negedge clk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      resp = bresp;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) bready <= 1'b0;
    end
  endtask

  task automatic axr(input logic [9:0] a, output logic [31:0] dat, output logic [1:0] resp);
    bit ar_t, r_t;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_t = 0;
    while (!r_t) begin
      @(negedge clk);
      ar_t = arvalid && arready;
      r_t = rvalid;
      dat = rdata;
      resp = rresp;
      @(posedge clk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) rready <= 1'b0;
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic load_fcw(input logic [7:0] v);
    @(posedge clk);
    fcw_wr <= 1'b1;
    fcw_d <= v;
    @(posedge clk);
    fcw_wr <= 1'b0;
    settle();
  endtask

  // Cycles spanned by k tick periods, starting on a tick
  task automatic tp(input int k, output int cnt);
    do @(negedge clk); while (tick !== 1'b1);
    cnt = 0;
    repeat (k) begin
      do begin
        @(negedge clk);
        cnt++;
      end while (tick !== 1'b1);
    end
  endtask

  // A hang is cut short well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst <= 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, fcw_wr, mode} <= 7'h00;
    {awaddr, araddr, wdata, fcw_d, lvl, div, raise} <= '0;
    wstrb <= 4'hf;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      axr(ba(IXS[i]), d, r);
      chk("reset value", d, EXP[i]);
    end
    for (int i = 4; i < 8; i++) begin
      axw(ba(IXS[i]), 32'hffffffff, r);
      chk("id write resp", r, UAX_RESP_OKAY);
      axr(ba(IXS[i]), d, r);
      chk("id after write", d, EXP[i]);
    end
    axw(10'h004, 32'h1, r);
    chk("unmapped write resp", r, UAX_RESP_SLVERR);
    axr(10'h004, d, r);
    chk("unmapped read resp", r, UAX_RESP_SLVERR);
    chk("unmapped read data", d, 0);
    load_fcw(8'hf1);
    @(posedge clk);
    mode <= 1'b1;
    for (int t = 0; t < 4; t++) begin
      axw(ba(UAX_IX_STET), 32'hfffffffc | t, r);
      settle();
      chk("fifo control word", fcw_q, 8'hc1 | (t << 4));
      axr(ba(UAX_IX_STET), d, r);
      chk("trigger readback", d, t);
      lvl <= LVL[t];
      settle();
      chk("flag at threshold", tx_holding_empty_flag, 1);
      @(posedge clk);
      lvl <= LVL[t] + 5'h01;
      settle();
      chk("flag above threshold", tx_holding_empty_flag, 0);
    end
    @(posedge clk);
    mode <= 1'b0;
    lvl <= LVL[1];
    settle();
    chk("flag mode off", tx_holding_empty_flag, 0);
    axw(ba(UAX_IX_HALT), 32'h1, r);
    settle();
    chk("halt set", hold, 1);
    axr(ba(UAX_IX_HALT), d, r);
    chk("halt readback", d, 1);
    load_fcw(8'h00);
    chk("halt fifo disabled", hold, 0);
    load_fcw(8'h01);
    chk("halt fifo enabled", hold, 1);
    axw(ba(UAX_IX_HALT), 32'h0, r);
    settle();
    chk("halt cleared", hold, 0);
    @(posedge clk);
    raise <= 4'hf;
    @(posedge clk);
    raise <= 4'h0;
    settle();
    chk("dma before ack", dreq, 4'hf);
    axw(ba(UAX_IX_ACK), 32'h1, r);
    settle();
    chk("dma after ack", dreq, 4'h0);
    axr(ba(UAX_IX_ACK), d, r);
    chk("ack reads zero", d, 0);
    @(posedge clk);
    raise <= 4'hf;
    @(posedge clk);
    raise <= 4'h0;
    settle();
    chk("dma after clear", dreq, 4'hf);
    @(posedge clk);
    div <= 16'h0004;
    axw(ba(UAX_IX_FRAC), 32'h0, r);
    tp(1, n);
    tp(1, n);
    chk("tick period", n, 4);
    axw(ba(UAX_IX_FRAC), 32'hfffffff8, r);
    axr(ba(UAX_IX_FRAC), d, r);
    chk("fraction readback", d, 8);
    tp(1, n);
    tp(16, n);
    chk("fractional span", n, 16 * 4 + 8);
    end_of_test();
  end
endmodule // uart_aux_control_regs_bench
`default_nettype wire

// >>> verification/uax_dma_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Far-side DMA request sources
// ****************************************
module uax_dma_peer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // One-cycle pulse raises a line
  input wire logic [3:0] raise,
  // Handshake lines as the controller sees them
  input wire logic [3:0] req,
  output logic [3:0] src
);
  // A dropped request counts as an ended transfer, so the source withdraws it
  always_ff @(posedge clk) begin
    if (rst) begin
      src <= 4'h0;
    end else begin
      src <= raise | (src & req);
    end
  end
endmodule // uax_dma_peer
`default_nettype wire
